// *** logic/output_driver_control.sv ***
// Purpose: Control words 1 and 2 and the output gating they steer
// Assumes: Register port is a decoded frame strobe, synchronous to clk
// Notes:   Frame serialisation and status registers sit outside
`timescale 1ns/1ps
`default_nettype none
`include "output_driver_regs.svh"

// Summary of operation
// - Outputs 7/8 pair: 10 low, 01 high
// - Word 1 bits 11..9 switch outputs 9..11
// - Gated output drives only while PWM high
// - Output 5 uses input B; others A
// - Never both bridge switches on together
// - Over-current sets status, switches output off
// - Recovery enable retries output after rate delay
// - One retry possible with recovery disabled
// - Words at addresses 01h and 02h, read/write
// - Device enable clear wipes both words
// - Rate bit: 0 is 1.7 kHz, 1 is 3 kHz
module output_driver_control
  import output_driver_pkg::*;
#(
  parameter int SLOW_CYCLES = `RECOVERY_CYCLES_SLOW,
  parameter int FAST_CYCLES = `RECOVERY_CYCLES_FAST
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register port
  input  wire logic          regWrite,
  input  wire logic          regRead,
  input  wire logic [5:0]    regAddress,
  input  wire logic [15:0]   regWriteData,
  output logic [15:0]        regReadData,
  output logic               regReadValid,
  // Device mode and recovery rate from neighbouring registers
  input  wire logic          deviceEnable,
  input  wire logic          recoveryRateFast,
  // Half bridge requests from control word 0
  input  wire bridge_drive_type bridgeRequest,
  // PWM inputs
  input  wire logic          pwm_input_a,
  input  wire logic          pwm_input_b,
  // Over-current events and status
  input  wire logic [5:0]    overcurrentEvent,
  input  wire logic          clearFaults,
  output logic [5:0]         overcurrentStatus,
  // Driver commands
  output bridge_drive_type   half_bridge_outputs,
  output high_side_drive_type highSideOutputs
);

  logic [15:0]      highSideControl;
  logic [15:0]      recoveryControl;
  logic [5:0]       shutOff;
  logic             recoveryTick;
  logic [31:0]      tickCount;
  bridge_drive_type next_bridge;
  high_side_drive_type next_highSide;

  function automatic resistance_type decodePair(input logic lowRes, input logic highRes);
    if (lowRes && !highRes) begin
      return RES_LOW;
    end else if (!lowRes && highRes) begin
      return RES_HIGH;
    end
    return RES_OFF;
  endfunction

  function automatic logic gate(input logic on, input logic gated, input logic pwm);
    return on && (!gated || pwm);
  endfunction

  function automatic logic [31:0] tickLimit(input logic fast);
    return 32'(fast ? FAST_CYCLES : SLOW_CYCLES) - 32'h1;
  endfunction

  // ************************************************************
  // Control word 1
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highSideControl <= `RESET_CONTROL_WORD;
    end else if (!deviceEnable) begin
      highSideControl <= `RESET_CONTROL_WORD;
    end else if (regWrite && regAddress == `ADDR_HIGH_SIDE_CONTROL) begin
      highSideControl <= regWriteData;
    end
  end

  // ************************************************************
  // Control word 2
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recoveryControl <= `RESET_CONTROL_WORD;
    end else if (!deviceEnable) begin
      recoveryControl <= `RESET_CONTROL_WORD;
    end else if (regWrite && regAddress == `ADDR_RECOVERY_CONTROL) begin
      recoveryControl <= regWriteData;
    end
  end

  // ************************************************************
  // Read valid
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regReadData <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddress)
        `ADDR_HIGH_SIDE_CONTROL: regReadData <= highSideControl;
        `ADDR_RECOVERY_CONTROL:  regReadData <= recoveryControl;
        default:                 regReadData <= 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // Recovery rate counter
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCount <= 32'h00000000;
    end else if (tickCount >= tickLimit(recoveryRateFast)) begin
      tickCount <= 32'h00000000;
    end else begin
      tickCount <= tickCount + 32'h1;
    end
  end

  // ************************************************************
  // Recovery rate tick
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recoveryTick <= 1'b0;
    end else begin
      recoveryTick <= (tickCount >= tickLimit(recoveryRateFast));
    end
  end

  // ************************************************************
  // Per-bridge over-current handling
  // ************************************************************
  for (genvar i = 0; i < 6; i++) begin : g_bridge
    overcurrent_recovery u_recovery (
      .clk              (clk),
      .rst_n            (rst_n),
      .recoveryEnable   (recoveryControl[`BIT_RECOVERY_EN_TOP - i]),
      .recoveryTick     (recoveryTick),
      .clearFault       (clearFaults || !deviceEnable),
      .overcurrentEvent (overcurrentEvent[5 - i]),
      .overcurrentStatus(overcurrentStatus[5 - i]),
      .shutOff          (shutOff[5 - i])
    );
  end

  // ************************************************************
  // Output gating
  // ************************************************************
  always_comb begin
    logic pwmSel;
    logic gateHigh;
    logic gateLow;
    pwmSel = 1'b0;
    gateHigh = 1'b0;
    gateLow = 1'b0;
    next_bridge = '0;
    for (int i = 0; i < 6; i++) begin
      pwmSel = (i == 4) ? pwm_input_b : pwm_input_a;
      gateHigh = gate(bridgeRequest.highSide[5 - i], recoveryControl[`BIT_PWM_GATE_TOP - i],
                      pwmSel);
      gateLow = gate(bridgeRequest.lowSide[5 - i], recoveryControl[`BIT_PWM_GATE_TOP - i],
                     pwmSel);
      if (!shutOff[5 - i] && !(gateHigh && gateLow)) begin
        next_bridge.highSide[5 - i] = gateHigh;
        next_bridge.lowSide[5 - i] = gateLow;
      end
    end
    next_highSide.outputSeven = decodePair(highSideControl[`BIT_OUTPUT_SEVEN_LOW_RES],
                                           highSideControl[`BIT_OUTPUT_SEVEN_HIGH_RES]);
    next_highSide.outputEight = decodePair(highSideControl[`BIT_OUTPUT_EIGHT_LOW_RES],
                                           highSideControl[`BIT_OUTPUT_EIGHT_HIGH_RES]);
    next_highSide.outputNine = highSideControl[`BIT_OUTPUT_NINE_ON];
    next_highSide.outputTen = highSideControl[`BIT_OUTPUT_TEN_ON];
    next_highSide.outputEleven = highSideControl[`BIT_OUTPUT_ELEVEN_ON];
  end

  // ************************************************************
  // Registered bridge commands
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_bridge_outputs <= '0;
    end else begin
      half_bridge_outputs <= next_bridge;
    end
  end

  // ************************************************************
  // Registered high-side commands
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highSideOutputs <= '0;
    end else begin
      highSideOutputs <= next_highSide;
    end
  end

endmodule
`default_nettype wire

// *** logic/output_driver_pkg.sv ***
// Purpose: Types shared by the output driver control logic
// Assumes: Nothing
// Notes:   Numbers live in output_driver_regs.svh
package output_driver_pkg;

  typedef enum logic [1:0] {
    RES_OFF  = 2'b00,
    RES_LOW  = 2'b01,
    RES_HIGH = 2'b10
  } resistance_type;

  typedef struct packed {
    logic [5:0] highSide;
    logic [5:0] lowSide;
  } bridge_drive_type;

  typedef struct packed {
    resistance_type outputSeven;
    resistance_type outputEight;
    logic           outputNine;
    logic           outputTen;
    logic           outputEleven;
  } high_side_drive_type;

endpackage

// *** logic/output_driver_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes:   Included by output_driver_control only
`ifndef OUTPUT_DRIVER_REGS_SVH
`define OUTPUT_DRIVER_REGS_SVH

`define ADDR_DEVICE_CONTROL      6'h00
`define ADDR_HIGH_SIDE_CONTROL   6'h01
`define ADDR_RECOVERY_CONTROL    6'h02
`define ADDR_RECOVERY_RATE_CTRL  6'h03
`define RESET_CONTROL_WORD       16'h0000
`define BIT_DEVICE_ENABLE        0
`define BIT_RECOVERY_RATE        5
`define BIT_OUTPUT_SEVEN_LOW_RES         15
`define BIT_OUTPUT_SEVEN_HIGH_RES        14
`define BIT_OUTPUT_EIGHT_LOW_RES         13
`define BIT_OUTPUT_EIGHT_HIGH_RES        12
`define BIT_OUTPUT_NINE_ON              11
`define BIT_OUTPUT_TEN_ON             10
`define BIT_OUTPUT_ELEVEN_ON             9
`define BIT_RECOVERY_EN_TOP      15
`define BIT_PWM_GATE_TOP         7
`define CLOCK_HZ                 100000000
`define RECOVERY_HZ_SLOW         1700
`define RECOVERY_HZ_FAST         3000
`define RECOVERY_CYCLES_SLOW     (`CLOCK_HZ / `RECOVERY_HZ_SLOW)
`define RECOVERY_CYCLES_FAST     (`CLOCK_HZ / `RECOVERY_HZ_FAST)

`endif

// *** logic/overcurrent_recovery.sv ***
// Purpose: Over-current latch and timed recovery for one half bridge
// Assumes: Recovery tick is a single-cycle pulse at the recovery rate
// Notes:   A recovery is a shutdown until the next tick, then retry
`timescale 1ns/1ps
`default_nettype none
module overcurrent_recovery (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic recoveryEnable,
  input  wire logic recoveryTick,
  input  wire logic clearFault,
  // Event and state
  input  wire logic overcurrentEvent,
  output logic      overcurrentStatus,
  output logic      shutOff
);

  logic pendingRetry;

  // ************************************************************
  // Shutdown and retry
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutOff      <= 1'b0;
      pendingRetry <= 1'b0;
    end else if (overcurrentEvent) begin
      shutOff      <= 1'b1;
      pendingRetry <= 1'b1;
    end else if (clearFault) begin
      shutOff      <= 1'b0;
      pendingRetry <= 1'b0;
    end else if (recoveryTick && shutOff && (recoveryEnable || pendingRetry)) begin
      shutOff      <= 1'b0;
      pendingRetry <= 1'b0;
    end
  end

  // ************************************************************
  // Sticky status, set wins over clear
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrentStatus <= 1'b0;
    end else if (overcurrentEvent) begin
      overcurrentStatus <= 1'b1;
    end else if (clearFault) begin
      overcurrentStatus <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** test/frame_master.sv ***
// Purpose: Controller model issuing register frames
// Assumes: Strobes change just after a rising edge
// Notes:   Tasks are called from the testbench
`timescale 1ns/1ps
`default_nettype none
module frame_master (
  // Register port
  input  wire logic        clk,
  input  wire logic [15:0] regReadData,
  input  wire logic        regReadValid,
  output logic             regWrite,
  output logic             regRead,
  output logic [5:0]       regAddress,
  output logic [15:0]      regWriteData
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddress = 6'h3F;
    regWriteData = 16'hFFFF;
  end
  // Unused bits are sent as zero by every caller
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddress <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regWriteData <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    regRead <= 1'b1;
    regAddress <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regReadData;
    v = regReadValid;
  endtask
endmodule
`default_nettype wire

// *** test/output_driver_checker.sv ***
// Purpose: Port checks for output_driver_control
// Assumes: One clock, async active-low reset
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module output_driver_checker
  import output_driver_pkg::*;
(
  // Watched ports
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                regWrite,
  input wire logic                regRead,
  input wire logic [5:0]          regAddress,
  input wire logic [15:0]         regWriteData,
  input wire logic                regReadValid,
  input wire logic                deviceEnable,
  input wire logic [5:0]          overcurrentEvent,
  input wire logic [5:0]          overcurrentStatus,
  input wire bridge_drive_type    half_bridge_outputs,
  input wire high_side_drive_type highSideOutputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (regRead |=> regReadValid)
    else $error("read not answered");
  valid_pulse_a: assert property (!regRead |=> !regReadValid)
    else $error("stray read valid");
  no_shoot_a: assert property ((half_bridge_outputs.highSide & half_bridge_outputs.lowSide) == 6'h00)
    else $error("both bridge switches on");
  oc_status_a: assert property (deviceEnable && overcurrentEvent != 6'h00 |=>
    (overcurrentStatus & $past(overcurrentEvent)) == $past(overcurrentEvent)) else $error("status not set");
  oc_off_a: assert property (overcurrentEvent[4] |=> ##1
    !half_bridge_outputs.highSide[4] && !half_bridge_outputs.lowSide[4]) else $error("bridge not off");
  standby_a: assert property (!deviceEnable [*2] |=> highSideOutputs == 7'h00)
    else $error("standby outputs on");
  nine_on_a: assert property (regWrite && deviceEnable && regAddress == 6'h01 && regWriteData[11]
    |=> ##1 highSideOutputs.outputNine) else $error("output nine off");
  low_res_a: assert property (regWrite && deviceEnable && regAddress == 6'h01 &&
    regWriteData[15:14] == 2'b10 |=> ##1 highSideOutputs.outputSeven == RES_LOW) else $error("bad decode");
  reset_zero_a: assert property ($rose(rst_n) |-> highSideOutputs == 7'h00 &&
    half_bridge_outputs == 12'h000) else $error("outputs not zero after reset");
  cover property (overcurrentEvent != 6'h00);
  cover property (regWrite && regAddress == 6'h02);
  cover property (!deviceEnable [*2]);
endmodule
bind output_driver_control output_driver_checker u_output_driver_checker (
  .clk                (clk),
  .rst_n              (rst_n),
  .regWrite           (regWrite),
  .regRead            (regRead),
  .regAddress         (regAddress),
  .regWriteData       (regWriteData),
  .regReadValid       (regReadValid),
  .deviceEnable       (deviceEnable),
  .overcurrentEvent   (overcurrentEvent),
  .overcurrentStatus  (overcurrentStatus),
  .half_bridge_outputs(half_bridge_outputs),
  .highSideOutputs    (highSideOutputs)
);
`default_nettype wire

// *** test/output_driver_control_tb.sv ***
// Purpose: Self-checking bench for output_driver_control
// Assumes: Recovery counts shortened to 8 and 4
// Notes:   Register frames come from frame_master
`timescale 1ns/1ps
`default_nettype none
module output_driver_control_tb
  import output_driver_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, deviceEnable = 1'b0, recoveryRateFast = 1'b0;
  logic pwm_input_a = 1'b0, pwm_input_b = 1'b0, clearFaults = 1'b0, regReadValid, v;
  logic regWrite, regRead;
  logic [5:0] overcurrentEvent = 6'h00, regAddress, overcurrentStatus;
  logic [15:0] regWriteData, regReadData, rd;
  bridge_drive_type bridgeRequest = 12'h000, half_bridge_outputs;
  high_side_drive_type highSideOutputs;
  int err_total = 0, num_checks = 0;
  always #5 clk = ~clk;
  output_driver_control #(.SLOW_CYCLES(8), .FAST_CYCLES(4)) u_output_driver_control (
    .clk                (clk),
    .rst_n              (rst_n),
    .regWrite           (regWrite),
    .regRead            (regRead),
    .regAddress         (regAddress),
    .regWriteData       (regWriteData),
    .regReadData        (regReadData),
    .regReadValid       (regReadValid),
    .deviceEnable       (deviceEnable),
    .recoveryRateFast   (recoveryRateFast),
    .bridgeRequest      (bridgeRequest),
    .pwm_input_a        (pwm_input_a),
    .pwm_input_b        (pwm_input_b),
    .overcurrentEvent   (overcurrentEvent),
    .clearFaults        (clearFaults),
    .overcurrentStatus  (overcurrentStatus),
    .half_bridge_outputs(half_bridge_outputs),
    .highSideOutputs    (highSideOutputs)
  );
  frame_master u_frame_master (
    .clk         (clk),
    .regReadData (regReadData),
    .regReadValid(regReadValid),
    .regWrite    (regWrite),
    .regRead     (regRead),
    .regAddress  (regAddress),
    .regWriteData(regWriteData)
  );
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic waitBack(input string n, input int lim);
    int k;
    k = 0;
    while (half_bridge_outputs !== 12'h400 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(n, 16'h0400, 16'(half_bridge_outputs));
  endtask
  task automatic rdchk(input string n, input logic [5:0] a, input logic [15:0] e);
    u_frame_master.rd(a, rd, v);
    chk("valid", 16'h0001, {15'h0000, v});
    chk(n, e, rd);
  endtask
  task automatic t_decode;
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (i == 2) ? 2'b01 : (i == 1) ? 2'b10 : 2'b00;
      u_frame_master.wr(6'h01, {i[1:0], i[1:0], i[1:0], i[0], 9'h000});
      settle;
      chk("high side", {9'h000, e, e, i[1:0], i[0]}, 16'(highSideOutputs));
      rdchk("word1", 6'h01, {i[1:0], i[1:0], i[1:0], i[0], 9'h000});
    end
  endtask
  task automatic t_standby;
    u_frame_master.wr(6'h02, 16'h8400);
    @(posedge clk) deviceEnable <= 1'b0;
    u_frame_master.wr(6'h01, 16'hE000);
    rdchk("standby word1", 6'h01, 16'h0000);
    rdchk("standby word2", 6'h02, 16'h0000);
    @(posedge clk) deviceEnable <= 1'b1;
  endtask
  task automatic t_bridge;
    @(posedge clk) bridgeRequest <= 12'h820;
    settle;
    chk("both", 16'h0000, 16'(half_bridge_outputs));
    @(posedge clk) bridgeRequest <= 12'h800;
    settle;
    chk("high only", 16'h0800, 16'(half_bridge_outputs));
  endtask
  task automatic t_pwm;
    u_frame_master.wr(6'h02, 16'h0088);
    @(posedge clk) bridgeRequest <= 12'h880;
    pwm_input_b <= 1'b1;
    settle;
    chk("pwm b", 16'h0080, 16'(half_bridge_outputs));
    @(posedge clk) pwm_input_a <= 1'b1;
    pwm_input_b <= 1'b0;
    settle;
    chk("pwm a", 16'h0800, 16'(half_bridge_outputs));
  endtask
  task automatic t_oc;
    u_frame_master.wr(6'h02, 16'h4000);
    @(posedge clk) bridgeRequest <= 12'h400;
    recoveryRateFast <= 1'b1;
    settle;
    @(posedge clk) overcurrentEvent <= 6'h10;
    @(posedge clk) overcurrentEvent <= 6'h00;
    @(posedge clk);
    #1;
    chk("status", 16'h0010, {10'h000, overcurrentStatus});
    chk("shut off", 16'h0000, 16'(half_bridge_outputs));
    waitBack("retry", 6);
    @(posedge clk) clearFaults <= 1'b1;
    @(posedge clk) clearFaults <= 1'b0;
    settle;
    chk("cleared", 16'h0000, {10'h000, overcurrentStatus});
  endtask
  task automatic t_retry_once;
    u_frame_master.wr(6'h02, 16'h0000);
    @(posedge clk) recoveryRateFast <= 1'b0;
    @(posedge clk) overcurrentEvent <= 6'h10;
    @(posedge clk) overcurrentEvent <= 6'h00;
    @(posedge clk);
    #1;
    chk("off again", 16'h0000, 16'(half_bridge_outputs));
    waitBack("single retry", 10);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    deviceEnable <= 1'b1;
    rdchk("reset word1", 6'h01, 16'h0000);
    rdchk("reset word2", 6'h02, 16'h0000);
    rdchk("unmapped", 6'h05, 16'h0000);
    t_decode;
    t_standby;
    t_bridge;
    t_pwm;
    t_oc;
    t_retry_once;
    finish_test;
  end
  initial begin
    #100000;
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
